// File: ims_start_ctrl.sv
// I2C master start control for a multi-master bus: bus monitor, start deferral,
// bus free interval, byte transmit and self-clearing event flags.
// Assumes open-drain bus lines resolved outside and a one-cycle register port.
//
// Summary of operation
// - A start requested while the bus is busy waits until the bus is released.
// - After a stop, a start waits 4.7us standard or 1.3us fast mode.
// - Multi-master transmitter start on a busy bus parks in a bus-polling wait state.
// - Start flag clears itself on a stop; stop and NACK flags clear themselves on a start.
// - Pending means flag and enable both set, regardless of global interrupt enable.
`timescale 1ns/1ns
module ims_start_ctrl
	import ims_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Register port
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// Bus clock line
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe,
	// Bus data line
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Interrupt
	output logic            irq
);

	ims_regs_t  r;
	ims_regs_t  next_r;
	logic [1:0] lines;
	logic       scl_s;
	logic       sda_s;
	logic       start_ev;
	logic       stop_ev;
	logic       tick;
	logic       free_ok;
	logic [7:0] tbuf_cnt;
	logic [3:0] ev_set;
	logic [3:0] ev_hw_clr;
	logic       load_byte;

	ims_sync u_sync (
		.clk        (clk),
		.arst_n     (arst_n),
		.line_in    ({scl_in, sda_in}),
		.line_level (lines)
	);

	assign scl_s = lines[1];
	assign sda_s = lines[0];

	function automatic logic [7:0] read_mux(input ims_regs_t s, input logic [2:0] a);
		logic [7:0] d;
		d = 8'h00;
		unique case (a)
			ADDR_CTRL: begin
				d[CTRL_START] = s.start_request;
				d[CTRL_STOP]  = s.stop_request;
				d[CTRL_MM]    = s.multi_master_select;
				d[CTRL_TR]    = s.transmitter_select;
				d[CTRL_FAST]  = s.fast_mode;
			end
			ADDR_STATUS: begin
				d[STAT_BUSY]    = s.bus_occupied_flag;
				d[STAT_WAITING] = (s.st == IMS_WAIT);
				d[STAT_ACTIVE]  = !(s.st inside {IMS_IDLE, IMS_WAIT});
				d[STAT_TXFULL]  = s.tx_full;
			end
			ADDR_IFLAG:  d[3:0] = s.event_flag;
			ADDR_IEN:    d[3:0] = s.event_irq_en;
			ADDR_TXDATA: d = s.txd;
			ADDR_CLKDIV: d = s.clkdiv;
			default:     d = 8'h00;
		endcase
		return d;
	endfunction

	always_comb begin
		next_r       = r;
		ev_set       = 4'h0;
		ev_hw_clr    = 4'h0;
		load_byte    = 1'b0;
		tick         = 1'b0;
		next_r.scl_q = scl_s;
		next_r.sda_q = sda_s;

		// Bus monitor: edges of data while clock is high
		start_ev = r.scl_q && scl_s && r.sda_q && !sda_s;
		stop_ev  = r.scl_q && scl_s && !r.sda_q && sda_s;
		if (start_ev) begin
			next_r.bus_occupied_flag = 1'b1;
			ev_set[EV_START]         = 1'b1;
			ev_hw_clr[EV_STOP]       = 1'b1;
			ev_hw_clr[EV_NACK]       = 1'b1;
		end
		if (stop_ev) begin
			next_r.bus_occupied_flag = 1'b0;
			ev_set[EV_STOP]          = 1'b1;
			ev_hw_clr[EV_START]      = 1'b1;
		end

		// Bus free interval since last stop
		tbuf_cnt = r.fast_mode ? TBUF_FAST_CNT : TBUF_STD_CNT;
		if (stop_ev || start_ev) begin
			next_r.free_cnt = 8'h00;
		end else if (r.free_cnt != FREE_RST) begin
			next_r.free_cnt = r.free_cnt + 8'h01;
		end
		free_ok = !r.bus_occupied_flag && (r.free_cnt >= tbuf_cnt);

		// Quarter-bit timer; a released clock held low by others stretches the phase
		if (r.st inside {IMS_IDLE, IMS_WAIT}) begin
			next_r.div = r.clkdiv;
		end else if (r.div == 8'h00) begin
			if (r.scl_low || scl_s) begin
				tick       = 1'b1;
				next_r.div = r.clkdiv;
			end
		end else begin
			next_r.div = r.div - 8'h01;
		end
		if (tick) begin
			next_r.ph = r.ph + 2'h1;
		end

		unique case (r.st)
			IMS_IDLE: begin
				next_r.scl_low = 1'b0;
				next_r.sda_low = 1'b0;
				next_r.ph      = 2'h0;
				next_r.rstart  = 1'b0;
				if (r.start_request) begin
					if (free_ok) begin
						next_r.st = IMS_START;
					end else begin
						next_r.st = IMS_WAIT;
					end
				end
			end
			IMS_WAIT: begin
				// Polls for release only; flags and holding register left alone
				next_r.ph = 2'h0;
				if (free_ok) begin
					next_r.st = IMS_START;
				end
			end
			IMS_START: begin
				next_r.scl_low = (r.ph == 2'h0) ? r.rstart : (r.ph == 2'h3);
				next_r.sda_low = (r.ph >= 2'h2);
				if (tick && r.ph == 2'h3) begin
					next_r.start_request = 1'b0;
					next_r.rstart        = 1'b0;
					ev_set[EV_TXRDY]     = 1'b1;
					if (r.tx_full) begin
						load_byte = 1'b1;
					end else begin
						next_r.st = IMS_HOLD;
					end
				end
			end
			IMS_BIT: begin
				next_r.scl_low = (r.ph < 2'h2);
				next_r.sda_low = !r.shift[7];
				if (tick && r.ph == 2'h3) begin
					if (r.bitn == 3'h0) begin
						next_r.st = IMS_ACK;
					end else begin
						next_r.shift = {r.shift[6:0], 1'b0};
						next_r.bitn  = r.bitn - 3'h1;
					end
				end
			end
			IMS_ACK: begin
				next_r.scl_low = (r.ph < 2'h2);
				next_r.sda_low = 1'b0;
				if (tick && r.ph == 2'h3) begin
					if (sda_s) begin
						ev_set[EV_NACK] = 1'b1;
						next_r.st       = IMS_STOP;
					end else if (r.stop_request) begin
						next_r.st = IMS_STOP;
					end else if (r.start_request) begin
						next_r.st     = IMS_START;
						next_r.rstart = 1'b1;
					end else if (r.tx_full) begin
						load_byte = 1'b1;
					end else begin
						next_r.st = IMS_HOLD;
					end
				end
			end
			IMS_HOLD: begin
				next_r.scl_low = 1'b1;
				next_r.sda_low = r.sda_low;
				next_r.ph      = 2'h0;
				if (r.stop_request) begin
					next_r.st = IMS_STOP;
				end else if (r.start_request) begin
					next_r.st     = IMS_START;
					next_r.rstart = 1'b1;
				end else if (r.tx_full) begin
					load_byte = 1'b1;
				end
			end
			IMS_STOP: begin
				next_r.scl_low = (r.ph == 2'h0);
				next_r.sda_low = (r.ph < 2'h2);
				if (tick && r.ph == 2'h3) begin
					next_r.stop_request = 1'b0;
					next_r.st           = IMS_IDLE;
				end
			end
			default: begin
				next_r.st = IMS_IDLE;
			end
		endcase

		// Holding register moves to the shifter only once the start is out
		if (load_byte) begin
			next_r.shift     = r.txd;
			next_r.tx_full   = 1'b0;
			next_r.bitn      = 3'h7;
			next_r.ph        = 2'h0;
			next_r.st        = IMS_BIT;
			ev_set[EV_TXRDY] = 1'b1;
		end

		// Register writes
		if (reg_wr) begin
			unique case (reg_addr)
				ADDR_CTRL: begin
					if (reg_wdata[CTRL_START]) begin
						next_r.start_request = 1'b1;
					end
					if (reg_wdata[CTRL_STOP]) begin
						next_r.stop_request = 1'b1;
					end
					next_r.multi_master_select = reg_wdata[CTRL_MM];
					next_r.transmitter_select  = reg_wdata[CTRL_TR];
					next_r.fast_mode           = reg_wdata[CTRL_FAST];
				end
				ADDR_IFLAG: begin
					ev_hw_clr = ev_hw_clr | reg_wdata[3:0];
				end
				ADDR_IEN: begin
					next_r.event_irq_en = reg_wdata[3:0];
				end
				ADDR_TXDATA: begin
					next_r.txd           = reg_wdata;
					next_r.tx_full       = 1'b1;
					ev_hw_clr[EV_TXRDY]  = 1'b1;
				end
				ADDR_CLKDIV: begin
					next_r.clkdiv = reg_wdata;
				end
				default: begin
				end
			endcase
		end

		// A new event wins over any clear in the same cycle
		next_r.event_flag = (r.event_flag & ~ev_hw_clr) | ev_set;

		next_r.rdata = reg_rd ? read_mux(r, reg_addr) : r.rdata;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	assign reg_rdata = r.rdata;
	assign scl_out   = 1'b0;
	assign scl_oe    = r.scl_low;
	assign sda_out   = 1'b0;
	assign sda_oe    = r.sda_low;
	// Pending needs only flag and enable; no global gate here
	assign irq       = |(r.event_flag & r.event_irq_en);

endmodule

// File: ims_pkg.sv
// Shared constants and types of the multi-master start control block.
// Assumes a 50 MHz system clock and an 8-bit register port.
package ims_pkg;

	// Clock and timing
	localparam int CLK_PERIOD_NS  = 20;
	localparam int TBUF_STD_NS    = 4700;
	localparam int TBUF_FAST_NS   = 1300;
	localparam int TBUF_STD_CYC   = (TBUF_STD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TBUF_FAST_CYC  = (TBUF_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] TBUF_STD_CNT  = 8'(TBUF_STD_CYC);
	localparam logic [7:0] TBUF_FAST_CNT = 8'(TBUF_FAST_CYC);

	// Register offsets
	localparam logic [2:0] ADDR_CTRL   = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h1;
	localparam logic [2:0] ADDR_IFLAG  = 3'h2;
	localparam logic [2:0] ADDR_IEN    = 3'h3;
	localparam logic [2:0] ADDR_TXDATA = 3'h4;
	localparam logic [2:0] ADDR_CLKDIV = 3'h5;

	// Control fields
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_MM    = 2;
	localparam int CTRL_TR    = 3;
	localparam int CTRL_FAST  = 4;

	// Status fields
	localparam int STAT_BUSY    = 0;
	localparam int STAT_WAITING = 1;
	localparam int STAT_ACTIVE  = 2;
	localparam int STAT_TXFULL  = 3;

	// Event flag fields, same layout in the enable register
	localparam int EV_START = 0;
	localparam int EV_STOP  = 1;
	localparam int EV_NACK  = 2;
	localparam int EV_TXRDY = 3;

	// Reset values
	localparam logic [7:0] CLKDIV_RST = 8'hFA;
	localparam logic [7:0] FREE_RST   = 8'hFF;

	typedef enum logic [6:0] {
		IMS_IDLE  = 7'h01,
		IMS_WAIT  = 7'h02,
		IMS_START = 7'h04,
		IMS_BIT   = 7'h08,
		IMS_ACK   = 7'h10,
		IMS_HOLD  = 7'h20,
		IMS_STOP  = 7'h40
	} ims_state_t;

	typedef struct packed {
		ims_state_t  st;
		logic [1:0]  ph;
		logic [7:0]  div;
		logic [2:0]  bitn;
		logic [7:0]  shift;
		logic [7:0]  txd;
		logic        tx_full;
		logic        rstart;
		logic        scl_low;
		logic        sda_low;
		logic        start_request;
		logic        stop_request;
		logic        multi_master_select;
		logic        transmitter_select;
		logic        fast_mode;
		logic [7:0]  clkdiv;
		logic [3:0]  event_flag;
		logic [3:0]  event_irq_en;
		logic        bus_occupied_flag;
		logic [7:0]  free_cnt;
		logic        scl_q;
		logic        sda_q;
		logic [7:0]  rdata;
	} ims_regs_t;

	localparam ims_regs_t REGS_RST = '{
		st: IMS_IDLE, ph: 2'h0, div: 8'h00, bitn: 3'h0, shift: 8'h00, txd: 8'h00,
		tx_full: 1'b0, rstart: 1'b0, scl_low: 1'b0, sda_low: 1'b0,
		start_request: 1'b0, stop_request: 1'b0, multi_master_select: 1'b0,
		transmitter_select: 1'b0, fast_mode: 1'b0, clkdiv: CLKDIV_RST,
		event_flag: 4'h0, event_irq_en: 4'h0, bus_occupied_flag: 1'b0,
		free_cnt: FREE_RST, scl_q: 1'b1, sda_q: 1'b1, rdata: 8'h00
	};

	typedef struct packed {
		logic [1:0] ff1;
		logic [1:0] ff2;
		logic [1:0] ff3;
		logic [1:0] level;
	} ims_sync_t;

	localparam ims_sync_t SYNC_RST = '{ff1: 2'h3, ff2: 2'h3, ff3: 2'h3, level: 2'h3};

endpackage

// File: ims_sync.sv
// Three-stage input synchroniser for the two bus lines.
// Lines idle high; a change is taken once stages two and three agree.
`timescale 1ns/1ns
module ims_sync
	import ims_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Raw and filtered lines
	input  wire logic [1:0] line_in,
	output logic      [1:0] line_level
);

	ims_sync_t r;
	ims_sync_t next_r;

	always_comb begin
		next_r     = r;
		next_r.ff1 = line_in;
		next_r.ff2 = r.ff1;
		next_r.ff3 = r.ff2;
		for (int i = 0; i < 2; i++) begin
			if (r.ff2[i] == r.ff3[i]) begin
				next_r.level[i] = r.ff3[i];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r <= SYNC_RST;
		end else begin
			r <= next_r;
		end
	end

	assign line_level = r.level;

endmodule

// File: ims_assertions.sv
// Port checker for the start control block.
// Assumes the resolved open-drain wire levels feed scl_in and sda_in.
`timescale 1ns/1ns
module ims_assertions
	import ims_pkg::*;
(
	// Clock and reset
	input wire logic       clk,
	input wire logic       arst_n,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Bus lines and interrupt
	input wire logic       scl_in,
	input wire logic       scl_oe,
	input wire logic       sda_in,
	input wire logic       sda_oe,
	input wire logic       irq
);
	logic       sda_d;
	logic       busy;
	logic       fbusy;
	logic       fast;
	logic [3:0] ien;
	logic [7:0] free;
	wire        st_ev = sda_d && !sda_in && scl_in;
	wire        sp_ev = !sda_d && sda_in && scl_in;

	// Shadow of wire events and software settings
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sda_d <= 1'b1;
			busy  <= 1'b0;
			fbusy <= 1'b0;
			fast  <= 1'b0;
			ien   <= 4'h0;
			free  <= 8'hFF;
		end else begin
			sda_d <= sda_in;
			busy  <= st_ev || (busy && !sp_ev);
			fbusy <= (st_ev && !sda_oe) || (fbusy && !sp_ev);
			free  <= (st_ev || sp_ev) ? 8'h00 : free + 8'(free != 8'hFF);
			if (reg_wr && reg_addr == ADDR_CTRL)
				fast <= reg_wdata[CTRL_FAST];
			if (reg_wr && reg_addr == ADDR_IEN)
				ien <= reg_wdata[3:0];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	sequence s_start;
		$rose(sda_oe) && !scl_oe;
	endsequence
	sequence s_stop;
		$fell(sda_oe) && !scl_oe;
	endsequence

	reset_quiet_a: assert property ($rose(arst_n) |-> !scl_oe && !sda_oe && !irq && reg_rdata == 8'h00)
		else $error("outputs not quiet after reset");
	unmapped_zero_a: assert property (reg_rd && reg_addr > 3'h5 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	irq_mask_a: assert property (ien == 4'h0 |-> !irq)
		else $error("irq with all enables off");
	busy_quiet_a: assert property (fbusy |-> !sda_oe && !scl_oe)
		else $error("drove bus while other master busy");
	tbuf_gap_a: assert property (s_start and !busy |-> free >= (fast ? TBUF_FAST_CNT : TBUF_STD_CNT))
		else $error("start before bus free time");
	start_hold_a: assert property (s_start |-> sda_oe until scl_oe)
		else $error("start data released early");
	start_bound_a: assert property (s_start |-> ##[1:1000] scl_oe)
		else $error("start clock never pulled low");
	stop_idle_a: assert property (s_stop |=> (!sda_oe && !scl_oe) [*8])
		else $error("bus driven right after stop");
endmodule

bind ims_start_ctrl ims_assertions ims_assertions_inst (
	.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in), .scl_oe(scl_oe), .sda_in(sda_in),
	.sda_oe(sda_oe), .irq(irq)
);

// File: ims_bus_model.sv
// Bus partner: another master that frames traffic, and a slave that acks.
// Assumes wires resolved by the bench; released lines float high.
`timescale 1ns/1ns
module ims_bus_model (
	// Clock and wires
	input  wire logic       clk,
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       ack_en,
	// Pull-downs and captured byte
	output logic            scl_low,
	output logic            sda_low,
	output logic      [7:0] byte_seen
);
	int nbit = 10;

	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		byte_seen = 8'h00;
	end
	// Slave side: capture one byte after a start, ack it if enabled
	always @(negedge sda) if (scl && !sda_low) nbit = 0;
	always @(posedge scl) if (nbit < 9) begin
		if (nbit < 8)
			byte_seen <= {byte_seen[6:0], sda};
		nbit++;
	end
	always @(negedge scl) if (nbit < 10) sda_low <= ack_en && nbit == 8;

	task automatic quarter();
		repeat (10) @(posedge clk);
	endtask
	task automatic bus_start();
		nbit = 10;
		@(posedge clk);
		sda_low <= 1'b1;
		quarter();
		scl_low <= 1'b1;
	endtask
	task automatic bus_clocks(input int n);
		repeat (n) begin
			quarter();
			scl_low <= 1'b0;
			quarter();
			scl_low <= 1'b1;
		end
	endtask
	task automatic bus_stop();
		quarter();
		sda_low <= 1'b1;
		quarter();
		scl_low <= 1'b0;
		quarter();
		sda_low <= 1'b0;
	endtask
endmodule

// File: testbench.sv
// Self-checking bench for the start control block.
// Assumes the bus partner model and the bound port checker.
`timescale 1ns/1ns
module testbench
	import ims_pkg::*;
;
	logic       clk;
	logic       arst_n;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_rdata;
	logic       scl_oe;
	logic       sda_oe;
	logic       irq;
	logic       p_scl_low;
	logic       p_sda_low;
	logic       ack_en;
	logic [7:0] byte_seen;
	int         n_fail;
	int         checks;
	int         cyc;
	wire        scl = !(scl_oe || p_scl_low);
	wire        sda = !(sda_oe || p_sda_low);

	ims_start_ctrl ims_start_ctrl_inst (
		.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl), .scl_out(), .scl_oe(scl_oe),
		.sda_in(sda), .sda_out(), .sda_oe(sda_oe), .irq(irq)
	);
	ims_bus_model ims_bus_model_inst (
		.clk(clk), .scl(scl), .sda(sda), .ack_en(ack_en), .scl_low(p_scl_low),
		.sda_low(p_sda_low), .byte_seen(byte_seen)
	);

	task automatic results();
		if (n_fail == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk($sformatf("reg%0d", a), d & m, e);
	endtask
	task automatic wait_bit(input logic [2:0] a, input int b, input logic v);
		logic [7:0] d;
		for (int i = 0; i < 3000; i++) begin
			rd(a, d);
			if (d[b] === v)
				break;
		end
		chk("wait", {7'h00, d[b]}, {7'h00, v});
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			$display("MISMATCH timeout expected done seen running");
			results();
		end
	end

	initial begin
		arst_n    = 1'b0;
		reg_addr  = 3'h0;
		reg_wdata = 8'h00;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		ack_en    = 1'b1;
		n_fail    = 0;
		checks    = 0;
		cyc       = 0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		rchk(ADDR_CLKDIV, 8'hFF, CLKDIV_RST);
		wr(3'h7, 8'hFF);
		rchk(3'h6, 8'hFF, 8'h00);
		rchk(ADDR_STATUS, 8'hFF, 8'h00);
		wr(ADDR_CLKDIV, 8'h02);
		wr(ADDR_IEN, 8'h0F);
		ims_bus_model_inst.bus_start();
		repeat (8) @(posedge clk);
		rchk(ADDR_IFLAG, 8'hFF, 8'h01);
		chk("irq", {7'h00, irq}, 8'h01);
		wr(ADDR_CTRL, 8'h0D);
		ims_bus_model_inst.bus_clocks(3);
		rchk(ADDR_STATUS, 8'h03, 8'h03);
		rchk(ADDR_IFLAG, 8'hFF, 8'h01);
		rchk(ADDR_CTRL, 8'h01, 8'h01);
		ims_bus_model_inst.bus_stop();
		repeat (8) @(posedge clk);
		rchk(ADDR_IFLAG, 8'h07, 8'h02);
		repeat (150) @(posedge clk);
		rchk(ADDR_STATUS, 8'h0F, 8'h02);
		wait_bit(ADDR_CTRL, CTRL_START, 1'b0);
		rchk(ADDR_IFLAG, 8'h0F, 8'h09);
		wr(ADDR_TXDATA, 8'hA5);
		wr(ADDR_CTRL, 8'h0E);
		wait_bit(ADDR_CTRL, CTRL_STOP, 1'b0);
		chk("byte", byte_seen, 8'hA5);
		rchk(ADDR_IFLAG, 8'h07, 8'h02);
		wr(ADDR_IEN, 8'h00);
		wr(ADDR_IFLAG, 8'h0F);
		ack_en <= 1'b0;
		rchk(ADDR_STATUS, 8'hFF, 8'h00);
		wr(ADDR_CTRL, 8'h1D);
		wait_bit(ADDR_CTRL, CTRL_START, 1'b0);
		wr(ADDR_TXDATA, 8'h3C);
		wait_bit(ADDR_IFLAG, EV_NACK, 1'b1);
		chk("irq", {7'h00, irq}, 8'h00);
		wr(ADDR_IEN, 8'h04);
		chk("irq", {7'h00, irq}, 8'h01);
		wait_bit(ADDR_STATUS, STAT_ACTIVE, 1'b0);
		rchk(ADDR_IFLAG, 8'h07, 8'h06);
		wr(ADDR_IFLAG, 8'h0F);
		chk("irq", {7'h00, irq}, 8'h00);
		// Repeated start from hold, standard mode, bus clock at its slow reset rate
		wr(ADDR_CLKDIV, CLKDIV_RST);
		wr(ADDR_CTRL, 8'h0D);
		wait_bit(ADDR_CTRL, CTRL_START, 1'b0);
		wr(ADDR_IFLAG, 8'h0F);
		wr(ADDR_CTRL, 8'h0D);
		rchk(ADDR_STATUS, 8'h06, 8'h04);
		wait_bit(ADDR_CTRL, CTRL_START, 1'b0);
		rchk(ADDR_IFLAG, 8'h0F, 8'h09);
		wr(ADDR_CTRL, 8'h0E);
		wait_bit(ADDR_CTRL, CTRL_STOP, 1'b0);
		rchk(ADDR_STATUS, 8'h0F, 8'h00);
		results();
	end
endmodule
